// ---- bpwm_top.sv ----
// Implementation choices: register access over AXI4-Lite and the address map.
module bpwm_top #(
    parameter bit HAS_CD = 1'b1
) (
    // clock and reset
    input  wire logic                        clock_i,
    input  wire logic                        rst_i,
    // axi4-lite write
    input  wire logic [bpwm_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                        s_axi_awvalid_i,
    output logic                             s_axi_awready_o,
    input  wire logic [31:0]                 s_axi_wdata_i,
    input  wire logic [3:0]                  s_axi_wstrb_i,
    input  wire logic                        s_axi_wvalid_i,
    output logic                             s_axi_wready_o,
    output logic [1:0]                       s_axi_bresp_o,
    output logic                             s_axi_bvalid_o,
    input  wire logic                        s_axi_bready_i,
    // axi4-lite read
    input  wire logic [bpwm_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                        s_axi_arvalid_i,
    output logic                             s_axi_arready_o,
    output logic [31:0]                      s_axi_rdata_o,
    output logic [1:0]                       s_axi_rresp_o,
    output logic                             s_axi_rvalid_o,
    input  wire logic                        s_axi_rready_i,
    // fault sources
    input  wire logic                        ext_fault_n_i,
    input  wire logic                        comparator_fault_level_i,
    // bridge pins
    output logic                             pwm_out_a_o,
    output logic                             pwm_out_a_oe_o,
    output logic                             pwm_out_b_o,
    output logic                             pwm_out_b_oe_o,
    output logic                             pwm_out_c_o,
    output logic                             pwm_out_c_oe_o,
    output logic                             pwm_out_d_o,
    output logic                             pwm_out_d_oe_o,
    output logic                             shutdown_status_o
);
    import bpwm_pkg::*;

    generate
        if (ADDR_W < 5) begin : g_chk
            $error("address too narrow for register map");
        end
    endgenerate

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        addr_ok = (a[1:0] == 2'b00) && (a <= ADDR_STAT);
    endfunction

    function automatic logic [15:0] wmerge(input logic [15:0] o, input logic [31:0] d,
                                           input logic [3:0] s);
        wmerge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction

    // ************************************************
    // register slave
    // ************************************************
    logic [11:0]        pwm_control_q;
    logic [9:0]         period_q;
    logic [7:0]         duty_high_bits_q;
    logic [7:0]         deadband_restart_control_q;
    logic [6:0]         shutdown_cfg_q;
    logic               shutdown_status_q;
    logic               aw_rdy_q, w_rdy_q, ar_rdy_q;
    logic [ADDR_W-1:0]  awaddr_q;
    logic [31:0]        wdata_q;
    logic [3:0]         wstrb_q;
    logic               bvalid_q, rvalid_q;
    logic [1:0]         bresp_q, rresp_q;
    logic [31:0]        rdata_q;
    logic [7:0]         period_timer_count_q;
    logic               run_q, dir_q;

    wire wr_go   = !aw_rdy_q && !w_rdy_q && !bvalid_q;
    wire wr_ok   = wr_go && addr_ok(awaddr_q);
    wire ar_take = ar_rdy_q && s_axi_arvalid_i;
    wire [15:0] wm_ctrl = wmerge({4'h0, pwm_control_q}, wdata_q, wstrb_q);
    wire [15:0] wm_per  = wmerge({6'h00, period_q}, wdata_q, wstrb_q);
    wire [15:0] wm_duty = wmerge({8'h00, duty_high_bits_q}, wdata_q, wstrb_q);
    wire [15:0] wm_db   = wmerge({8'h00, deadband_restart_control_q}, wdata_q, wstrb_q);
    wire [15:0] wm_sd   = wmerge({8'h00, shutdown_status_q, shutdown_cfg_q}, wdata_q, wstrb_q);
    wire wr_sd  = wr_ok && (awaddr_q == ADDR_SD) && wstrb_q[0];
    wire fw_set = wr_sd && wm_sd[SD_STAT];
    wire fw_clr = wr_sd && !wm_sd[SD_STAT];
    wire [31:0] rd_word =
        (s_axi_araddr_i == ADDR_CTRL) ? {20'h0, pwm_control_q} :
        (s_axi_araddr_i == ADDR_PER)  ? {22'h0, period_q} :
        (s_axi_araddr_i == ADDR_DUTY) ? {24'h0, duty_high_bits_q} :
        (s_axi_araddr_i == ADDR_DB)   ? {24'h0, deadband_restart_control_q} :
        (s_axi_araddr_i == ADDR_SD)   ? {24'h0, shutdown_status_q, shutdown_cfg_q} :
        (s_axi_araddr_i == ADDR_STAT) ? {21'h0, shutdown_status_q, run_q, dir_q, period_timer_count_q} :
        32'h0000_0000;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            aw_rdy_q <= 1'b1;
            w_rdy_q  <= 1'b1;
            awaddr_q <= '0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else begin
            if (aw_rdy_q && s_axi_awvalid_i) begin
                aw_rdy_q <= 1'b0;
                awaddr_q <= s_axi_awaddr_i;
            end
            if (w_rdy_q && s_axi_wvalid_i) begin
                w_rdy_q <= 1'b0;
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
                aw_rdy_q <= 1'b1;
                w_rdy_q  <= 1'b1;
            end else if (bvalid_q && s_axi_bready_i) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ar_rdy_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            ar_rdy_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= addr_ok(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_q <= 1'b0;
            ar_rdy_q <= 1'b1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pwm_control_q              <= 12'h000;
            period_q                   <= 10'h000;
            duty_high_bits_q           <= 8'h00;
            deadband_restart_control_q <= 8'h00;
            shutdown_cfg_q             <= 7'h00;
        end else if (wr_ok) begin
            if (awaddr_q == ADDR_CTRL) pwm_control_q <= wm_ctrl[11:0];
            if (awaddr_q == ADDR_PER)  period_q <= wm_per[9:0];
            if (awaddr_q == ADDR_DUTY) duty_high_bits_q <= wm_duty[7:0];
            if (awaddr_q == ADDR_DB)   deadband_restart_control_q <= wm_db[7:0];
            if (awaddr_q == ADDR_SD)   shutdown_cfg_q <= wm_sd[6:0];
        end
    end

    // ************************************************
    // shutdown
    // ************************************************
    wire [2:0] src   = shutdown_cfg_q[SD_SRC +: 3];
    wire       rsen  = deadband_restart_control_q[DB_RSEN];
    wire       cond  = (src[SRC_PIN] && !ext_fault_n_i)
                     || (src[SRC_CMP] && comparator_fault_level_i);
    // set wins; a clear while the level stands is dropped
    wire       sd_d  = (cond || fw_set) ? 1'b1 :
                       fw_clr ? 1'b0 :
                       (rsen && !cond) ? 1'b0 : shutdown_status_q;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) shutdown_status_q <= 1'b0;
        else shutdown_status_q <= sd_d;
    end

    // ************************************************
    // time base
    // ************************************************
    logic [5:0] fine_q;
    logic [9:0] duty_lat_q;
    wire        en     = pwm_control_q[CTRL_EN];
    wire [1:0]  cfg    = pwm_control_q[CTRL_CFG +: 2];
    wire [1:0]  pol    = pwm_control_q[CTRL_POL +: 2];
    wire [7:0]  pr     = period_q[PER_PR +: 8];
    wire [1:0]  ps     = period_q[PER_PS +: 2];
    wire [5:0]  ps_n   = (ps == PS_1) ? PS_N1 : (ps == PS_4) ? PS_N4 : PS_N16;
    // one timer count is one instruction cycle times prescale
    wire [5:0]  fine_last = 6'((7'(ps_n) << 2) - 7'd1);
    wire [1:0]  low2   = (ps == PS_1) ? fine_q[1:0] :
                         (ps == PS_4) ? fine_q[3:2] : fine_q[5:4];
    wire [9:0]  base10 = {period_timer_count_q, low2};
    wire        tick   = fine_q == fine_last;
    wire        per_end = tick && (period_timer_count_q == pr);
    wire        pwm_raw = run_q && (base10 < duty_lat_q);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            fine_q <= 6'h00;
            period_timer_count_q <= 8'h00;
            duty_lat_q <= 10'h000;
            run_q <= 1'b0;
        end else begin
            fine_q <= (!en || tick) ? 6'h00 : fine_q + 6'h01;
            if (!en || per_end) period_timer_count_q <= 8'h00;
            else if (tick) period_timer_count_q <= period_timer_count_q + 8'h01;
            if (per_end) duty_lat_q <= {duty_high_bits_q, pwm_control_q[CTRL_DLO +: 2]};
            // output only from a fresh period, after enable or restart
            if (!en || shutdown_status_q) run_q <= 1'b0;
            else if (per_end) run_q <= 1'b1;
        end
    end

    // ************************************************
    // direction change
    // ************************************************
    bpwm_dir_state_type ds_q;
    wire full     = cfg[0];
    wire want     = cfg[1];
    wire mismatch = want != dir_q;
    wire near_end = ({1'b0, period_timer_count_q} + DIR_LEAD - 9'd1) >= {1'b0, pr};
    wire blank    = full && run_q && ((ds_q == DS_BLANK) || (mismatch && near_end));
    // unmodulated pair swaps prescale clocks before period end
    wire swap_due = blank && mismatch && (period_timer_count_q == pr)
                    && (fine_q == fine_last - ps_n);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            dir_q <= 1'b0;
            ds_q  <= DS_IDLE;
        end else if (!full || !run_q) begin
            dir_q <= want;
            ds_q  <= DS_IDLE;
        end else begin
            case (ds_q)
                DS_IDLE:  if (blank && !per_end) ds_q <= DS_BLANK;
                DS_BLANK: if (per_end) ds_q <= DS_IDLE;
                default:  ds_q <= DS_IDLE;
            endcase
            if (swap_due) dir_q <= want;
        end
    end

    // ************************************************
    // dead band
    // ************************************************
    logic       pwm_q;
    logic       run_p_q;
    logic [8:0] db_cnt_q;
    wire  [8:0] db_lim  = 9'(deadband_restart_control_q[DB_CNT +: 7]) * CLKS_PER_INSTR;
    wire        db_done = db_cnt_q >= db_lim;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pwm_q    <= 1'b0;
            run_p_q  <= 1'b0;
            db_cnt_q <= 9'h000;
        end else begin
            pwm_q <= pwm_raw;
            // run delayed to line up with pwm_q, gates the idle-active pins
            run_p_q <= run_q;
            // counter restarts on every edge, so only turn-on waits
            if (pwm_raw != pwm_q) db_cnt_q <= 9'h000;
            else if (!db_done) db_cnt_q <= db_cnt_q + 9'h001;
        end
    end

    // ************************************************
    // output steering and shutdown
    // ************************************************
    logic [3:0] act, pin_en, lvl_q, oe_q;
    wire        mod = pwm_q && !blank;
    wire [3:0]  steer = pwm_control_q[CTRL_STR +: 4];

    always_comb begin
        act    = 4'h0;
        pin_en = 4'h0;
        case (cfg)
            CFG_SINGLE: begin
                act    = {4{pwm_q}};
                pin_en = steer;
            end
            CFG_HALF: begin
                act    = {2'b00, !pwm_q && db_done && run_p_q, pwm_q && db_done};
                pin_en = 4'h3;
            end
            CFG_FWD, CFG_REV: begin
                // no dead band in either full-bridge direction
                act    = {4{run_p_q}} & {!dir_q && mod, dir_q, dir_q && mod, !dir_q};
                pin_en = 4'hf;
            end
            default: begin
                act    = 4'h0;
                pin_en = 4'h0;
            end
        endcase
        if (!en) pin_en = 4'h0;
        if (!HAS_CD) pin_en[3:2] = 2'b00;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            wire [1:0] safe = (gi % 2 == 0) ? shutdown_cfg_q[SD_AC +: 2]
                                            : shutdown_cfg_q[SD_BD +: 2];
            wire       sd_lvl = safe == SAFE_HIGH;
            wire       sd_oe  = (safe == SAFE_HIGH) || (safe == SAFE_LOW);
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    lvl_q[gi] <= 1'b0;
                    oe_q[gi]  <= 1'b0;
                end else if (shutdown_status_q || cond) begin
                    lvl_q[gi] <= sd_lvl;
                    oe_q[gi]  <= pin_en[gi] && sd_oe;
                end else begin
                    lvl_q[gi] <= act[gi] ^ pol[gi % 2];
                    oe_q[gi]  <= pin_en[gi];
                end
            end
        end
    endgenerate

    assign pwm_out_a_o       = lvl_q[0];
    assign pwm_out_b_o       = lvl_q[1];
    assign pwm_out_c_o       = lvl_q[2];
    assign pwm_out_d_o       = lvl_q[3];
    assign pwm_out_a_oe_o    = oe_q[0];
    assign pwm_out_b_oe_o    = oe_q[1];
    assign pwm_out_c_oe_o    = oe_q[2];
    assign pwm_out_d_oe_o    = oe_q[3];
    assign shutdown_status_o = shutdown_status_q;
    assign s_axi_awready_o   = aw_rdy_q;
    assign s_axi_wready_o    = w_rdy_q;
    assign s_axi_bvalid_o    = bvalid_q;
    assign s_axi_bresp_o     = bresp_q;
    assign s_axi_arready_o   = ar_rdy_q;
    assign s_axi_rvalid_o    = rvalid_q;
    assign s_axi_rdata_o     = rdata_q;
    assign s_axi_rresp_o     = rresp_q;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    AST_HALF_NO_OVERLAP: assert property ((cfg == CFG_HALF) |-> !(act[0] && act[1]))
        else $error("half bridge drives a and b active together");
    AST_DB_HOLD: assert property (($rose(pwm_q) && cfg == CFG_HALF && db_lim != 9'h000)
                                  |-> !act[0] [*2])
        else $error("dead band not held after rising edge");
    AST_FWD: assert property ((cfg == CFG_FWD && dir_q == 1'b0 && en && run_p_q)
                              |-> act[0] && !act[1] && !act[2])
        else $error("forward pattern wrong");
    AST_REV: assert property ((cfg == CFG_REV && dir_q && en && run_p_q)
                              |-> act[2] && !act[0] && !act[3])
        else $error("reverse pattern wrong");
    AST_SD_SET: assert property (cond |=> shutdown_status_q [*1])
        else $error("shutdown status not set by condition");
    AST_SD_HOLD: assert property ((shutdown_status_q && cond && fw_clr) |=> shutdown_status_q)
        else $error("clear took effect during condition");
    AST_AUTO_RST: assert property ((shutdown_status_q && rsen && !cond && !fw_set)
                                   |=> !shutdown_status_q)
        else $error("auto restart did not clear status");
    AST_RESUME: assert property ($rose(run_q) |-> $past(per_end))
        else $error("output resumed mid period");
    AST_SAFE_A: assert property ((shutdown_status_q && pin_en[0] && !shutdown_cfg_q[SD_AC + 1])
                                 |=> pwm_out_a_oe_o && (pwm_out_a_o == $past(shutdown_cfg_q[SD_AC])))
        else $error("pin a not in its driven safe state");
    AST_START_QUIET: assert property (!run_p_q |-> (act == 4'h0))
        else $error("pins active before first period start");
    AST_DIR_SWAP: assert property (($changed(dir_q) && $past(run_q) && $past(full))
                                   |-> $past(blank))
        else $error("direction swapped outside blank window");

    CV_HALF: cover property (cfg == CFG_HALF && act[0] ##[1:600] act[1]);
    CV_SWAP: cover property (swap_due ##[1:16] per_end);
    CV_RESTART: cover property ($fell(shutdown_status_q) && rsen);
endmodule

// ---- bpwm_pkg.sv ----
package bpwm_pkg;
    // ************************************************
    // register map
    // ************************************************
    localparam int             ADDR_W    = 8;
    localparam logic [7:0]     ADDR_CTRL = 8'h00;
    localparam logic [7:0]     ADDR_PER  = 8'h04;
    localparam logic [7:0]     ADDR_DUTY = 8'h08;
    localparam logic [7:0]     ADDR_DB   = 8'h0c;
    localparam logic [7:0]     ADDR_SD   = 8'h10;
    localparam logic [7:0]     ADDR_STAT = 8'h14;
    localparam logic [1:0]     RESP_OKAY = 2'b00;
    localparam logic [1:0]     RESP_SLVERR = 2'b10;
    // ************************************************
    // field positions
    // ************************************************
    localparam int CTRL_CFG = 0;
    localparam int CTRL_POL = 2;
    localparam int CTRL_DLO = 4;
    localparam int CTRL_EN  = 6;
    localparam int CTRL_STR = 8;
    localparam int PER_PR   = 0;
    localparam int PER_PS   = 8;
    localparam int DB_CNT   = 0;
    localparam int DB_RSEN  = 7;
    localparam int SD_BD    = 0;
    localparam int SD_AC    = 2;
    localparam int SD_SRC   = 4;
    localparam int SD_STAT  = 7;
    localparam int SRC_PIN  = 0;
    localparam int SRC_CMP  = 1;
    // ************************************************
    // encodings and timing
    // ************************************************
    localparam logic [1:0] CFG_SINGLE = 2'b00;
    localparam logic [1:0] CFG_HALF   = 2'b10;
    localparam logic [1:0] CFG_FWD    = 2'b01;
    localparam logic [1:0] CFG_REV    = 2'b11;
    localparam logic [1:0] SAFE_LOW   = 2'b00;
    localparam logic [1:0] SAFE_HIGH  = 2'b01;
    localparam logic [1:0] PS_1       = 2'b00;
    localparam logic [1:0] PS_4       = 2'b01;
    localparam logic [5:0] PS_N1      = 6'd1;
    localparam logic [5:0] PS_N4      = 6'd4;
    localparam logic [5:0] PS_N16     = 6'd16;
    localparam logic [8:0] CLKS_PER_INSTR = 9'd4;
    localparam logic [8:0] DIR_LEAD   = 9'd4;
    typedef enum logic {DS_IDLE, DS_BLANK} bpwm_dir_state_type;
endpackage

// ---- bpwm_fault_model.sv ----
module bpwm_fault_model (
    // commands from the bench
    input  wire logic pin_cmd_i,
    input  wire logic cmp_cmd_i,
    // fault lines toward the block
    output logic      ext_fault_n_o,
    output logic      comparator_fault_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************
    // level sources, held while commanded
    // ********************************
    assign ext_fault_n_o            = ~pin_cmd_i;
    assign comparator_fault_level_o = cmp_cmd_i;
endmodule

// ---- tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bpwm_pkg::*;
    // ********************************
    // stimulus and observed signals
    // ********************************
    logic        clock_i = 0, rst_i = 1, pin_cmd = 0, cmp_cmd = 0;
    logic [7:0]  s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
    logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
    logic [3:0]  s_axi_wstrb_i = 4'hf, po, oe;
    logic        s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
    logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic        ext_fault_n_i, comparator_fault_level_i, shutdown_status_o;
    int          n_errors = 0, n_compared = 0, cyc = 0, cnt[5];
    always #10 clock_i = ~clock_i;
    bpwm_fault_model faults (.pin_cmd_i(pin_cmd), .cmp_cmd_i(cmp_cmd), .ext_fault_n_o(ext_fault_n_i),
        .comparator_fault_level_o(comparator_fault_level_i));
    bpwm_top DUT (.clock_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
        .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
        .s_axi_rready_i, .ext_fault_n_i, .comparator_fault_level_i, .shutdown_status_o,
        .pwm_out_a_o(po[0]), .pwm_out_a_oe_o(oe[0]), .pwm_out_b_o(po[1]), .pwm_out_b_oe_o(oe[1]),
        .pwm_out_c_o(po[2]), .pwm_out_c_oe_o(oe[2]), .pwm_out_d_o(po[3]), .pwm_out_d_oe_o(oe[3]));
    // ********************************
    // checking and bus tasks
    // ********************************
    task automatic final_report();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // ready is sampled mid-cycle so the release lands right after the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, b;
        logic [1:0] r;
        b = 0;
        @(posedge clock_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
        while (!b) begin
            @(negedge clock_i);
            ta = s_axi_awvalid_i & s_axi_awready_o;
            tw = s_axi_wvalid_i & s_axi_wready_o;
            b = s_axi_bvalid_o;
            r = s_axi_bresp_o;
            @(posedge clock_i);
            if (ta) s_axi_awvalid_i <= 0;
            if (tw) s_axi_wvalid_i <= 0;
            if (b) s_axi_bready_i <= 0;
        end
        chk("bresp", er, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, b;
        logic [31:0] d;
        logic [1:0] r;
        b = 0;
        @(posedge clock_i);
        s_axi_araddr_i <= a;
        {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
        while (!b) begin
            @(negedge clock_i);
            ta = s_axi_arvalid_i & s_axi_arready_o;
            b = s_axi_rvalid_o;
            d = s_axi_rdata_o;
            r = s_axi_rresp_o;
            @(posedge clock_i);
            if (ta) s_axi_arvalid_i <= 0;
            if (b) s_axi_rready_i <= 0;
        end
        chk("rdata", ed, d);
        chk("rresp", er, r);
    endtask
    // active clocks per pin over one 40-clock period, plus a/b overlap
    task automatic meas();
        repeat (100) @(posedge clock_i);
        cnt = '{default:0};
        repeat (40) begin
            @(negedge clock_i);
            for (int i = 0; i < 4; i++) cnt[i] += po[i];
            cnt[4] += po[0] & po[1];
        end
    endtask
    function automatic int dbw(int w, int d);
        return (w > 4 * d) ? w - 4 * d : 0;
    endfunction
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    // ********************************
    // main sequence
    // ********************************
    initial begin
        int dh, dl, d10, db;
        void'($urandom(32'hef01));
        repeat (5) @(posedge clock_i);
        rst_i <= 0;
        chk("oe_reset", 4'h0, oe);
        rd(ADDR_STAT, 0, RESP_OKAY);
        rd(8'h18, 0, RESP_SLVERR);
        wr(8'h3c, 1, RESP_SLVERR);
        wr(ADDR_PER, 32'h9, RESP_OKAY);
        for (int k = 0; k < 3; k++) begin
            dh = $urandom % 8 + 1;
            dl = $urandom % 4;
            d10 = dh * 4 + dl;
            db = (k == 2) ? 127 : k * 2;
            wr(ADDR_DUTY, dh, RESP_OKAY);
            wr(ADDR_DB, db, RESP_OKAY);
            wr(ADDR_CTRL, 32'h40 | dl << 4 | CFG_HALF, RESP_OKAY);
            meas();
            chk("a_width", dbw(d10, db), cnt[0]);
            chk("b_width", dbw(40 - d10, db), cnt[1]);
            chk("ab_overlap", 0, cnt[4]);
        end
        wr(ADDR_DB, 5, RESP_OKAY);
        for (int m = 0; m < 2; m++) begin
            // low duty for two periods before reversing, against shoot-through
            if (m) begin
                wr(ADDR_DUTY, 1, RESP_OKAY);
                repeat (80) @(posedge clock_i);
            end
            wr(ADDR_CTRL, 32'h40 | dl << 4 | (m ? CFG_REV : CFG_FWD), RESP_OKAY);
            wr(ADDR_DUTY, dh, RESP_OKAY);
            meas();
            chk("a_width", m ? 0 : 40, cnt[0]);
            chk("b_width", m ? d10 : 0, cnt[1]);
            chk("c_width", m ? 40 : 0, cnt[2]);
            chk("d_width", m ? 0 : d10, cnt[3]);
        end
        wr(ADDR_SD, 32'h29, RESP_OKAY);
        cmp_cmd <= 1;
        repeat (3) @(posedge clock_i);
        chk("oe_safe", 4'b1010, oe);
        chk("bd_safe", 2'b11, {po[3], po[1]});
        chk("status", 1, shutdown_status_o);
        wr(ADDR_SD, 32'h29, RESP_OKAY);
        chk("status", 1, shutdown_status_o);
        cmp_cmd <= 0;
        repeat (3) @(posedge clock_i);
        chk("status", 1, shutdown_status_o);
        wr(ADDR_SD, 32'h29, RESP_OKAY);
        chk("status", 0, shutdown_status_o);
        wr(ADDR_DB, 32'h80, RESP_OKAY);
        wr(ADDR_SD, 32'h11, RESP_OKAY);
        pin_cmd <= 1;
        repeat (3) @(posedge clock_i);
        chk("status", 1, shutdown_status_o);
        chk("ac_safe", 2'b00, {po[2], po[0]});
        pin_cmd <= 0;
        repeat (3) @(posedge clock_i);
        chk("status", 0, shutdown_status_o);
        meas();
        chk("c_width", 40, cnt[2]);
        wr(ADDR_CTRL, 32'h540 | dl << 4 | CFG_SINGLE, RESP_OKAY);
        meas();
        chk("a_width", d10, cnt[0]);
        chk("c_width", d10, cnt[2]);
        chk("b_oe", 0, oe[1]);
        wr(ADDR_CTRL, 32'hf48 | dl << 4 | CFG_SINGLE, RESP_OKAY);
        meas();
        chk("a_width", d10, cnt[0]);
        chk("b_width", 40 - d10, cnt[1]);
        chk("oe_steer", 4'hf, oe);
        final_report();
    end
endmodule
